// >>> event_counter_pkg.sv
// Package: register map, field layout, reset values and counter limits
package event_counter_pkg;

    // ------------------------------------------------------------
    // Register indices (word address = index, byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0]  IDX_BANK_ONE   = 8'h12;
    localparam logic [7:0]  IDX_BANK_TWO   = 8'h13;
    localparam logic [7:0]  IDX_FALSE_CAR  = 8'h14;
    localparam logic [7:0]  IDX_RX_ERR     = 8'h15;
    localparam logic [7:0]  IDX_INT_CTRL   = 8'h11;

    // ------------------------------------------------------------
    // Interrupt control field positions
    // ------------------------------------------------------------
    localparam int          CTRL_OUT_EN    = 0;
    localparam int          CTRL_INT_EN    = 1;
    localparam int          CTRL_TEST_INT  = 2;
    localparam int          CTRL_POLARITY  = 3;
    localparam logic [15:0] CTRL_RESET     = 16'h0008;
    localparam logic [15:0] CTRL_WMASK     = 16'h000F;

    // ------------------------------------------------------------
    // Bank field layout
    // ------------------------------------------------------------
    localparam int          STAT_LSB       = 8;
    localparam int          EVT_W          = 8;
    localparam int          BANK1_FC_BIT   = 1;
    localparam int          BANK1_RE_BIT   = 0;
    localparam logic [7:0]  EN_RESET       = 8'h00;

    // ------------------------------------------------------------
    // Counter limits
    // ------------------------------------------------------------
    localparam int          FC_W           = 8;
    localparam int          RE_W           = 16;
    localparam logic [15:0] CNT_MAX        = 16'h00FF;
    localparam logic [15:0] CNT_HALF       = 16'h007F;

    localparam logic [31:0] RD_ZERO        = 32'h0000_0000;

endpackage

// >>> sat_counter.sv
// Saturating clear-on-read event counter with half-full crossing pulse
`timescale 1ns/100ps
module sat_counter
    import event_counter_pkg::*;
#(
    parameter int          WIDTH = 16,
    parameter logic [15:0] MAXV  = CNT_MAX,
    parameter logic [15:0] HALFV = CNT_HALF
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             inc_i,
    input  wire logic             clr_i,
    output logic [WIDTH-1:0]      count_o,
    output logic                  half_o
);

    initial begin
        if (WIDTH < 8 || WIDTH > 16) begin
            $error("sat_counter WIDTH must be 8 to 16");
        end
    end

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             half;
    } state_s;

    state_s st_q;
    state_s st_d;

    always_comb begin
        st_d      = st_q;
        st_d.half = 1'b0;
        if (clr_i) begin
            // RQ21: increment survives read
            st_d.cnt = inc_i ? WIDTH'(1) : '0;
        end else if (inc_i && st_q.cnt < MAXV[WIDTH-1:0]) begin
            // RQ11: stop at maximum
            st_d.cnt = st_q.cnt + WIDTH'(1);
            // RQ15: half-full crossing event
            st_d.half = (st_q.cnt == HALFV[WIDTH-1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count_o = st_q.cnt;
    assign half_o  = st_q.half;

endmodule // sat_counter

// >>> event_bank.sv
// Bank of eight clear-on-read status bits with matching enables
`timescale 1ns/100ps
module event_bank
    import event_counter_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [EVT_W-1:0] evt_i,
    input  wire logic             rd_i,
    input  wire logic             wr_i,
    input  wire logic [EVT_W-1:0] wen_i,
    output logic [15:0]           value_o,
    output logic                  pend_o
);

    typedef struct packed {
        logic [EVT_W-1:0] stat;
        logic [EVT_W-1:0] en;
    } state_s;

    state_s st_q;
    state_s st_d;

    always_comb begin
        st_d = st_q;
        // RQ21: set wins over read clear
        st_d.stat = (rd_i ? '0 : st_q.stat) | evt_i;
        // RQ9: writable enables
        if (wr_i) begin
            st_d.en = wen_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= {{EVT_W{1'b0}}, EN_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign value_o = {st_q.stat, st_q.en};
    // RQ20: pending when status and enable
    assign pend_o  = |(st_q.stat & st_q.en);

endmodule // event_bank

// >>> phy_event_status.sv
// Top: event banks, error counters, interrupt pin and Wishbone slave
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/100ps

// Functional notes
// RQ1: Bank two bit 15 latches energy-efficient-Ethernet error, clears on read.
// RQ2: Bank two bit 14 latches auto-negotiation error, clears on read.
// RQ3: Bank two bit 13 latches page received, clears on read.
// RQ4: Bank two bit 12 latches loopback FIFO overflow or underflow.
// RQ5: Bank two bit 11 latches pair assignment change, clears on read.
// RQ6: Bank two bit 10 latches sleep-mode event until read.
// RQ7: Bank two bit 9 shared by inverted polarity and wake packet.
// RQ8: Bank two bit 8 latches jabber detection, clears on read.
// RQ9: Enable bits 7..0 reset to zero, gate status bits 15..8.
// RQ10: Eight-bit false-carrier counter counts each event, upper bits zero.
// RQ11: False-carrier counter saturates at FFh, event when passing 7Fh.
// RQ12: Reading either counter register resets it to zero.
// RQ13: Sixteen-bit receive-error counter counts errors while data valid.
// RQ14: Receive-error counting suspended during interface loopback.
// RQ15: Receive-error counter saturates at FFh, event passing 7Fh.
// RQ16: Half-full events land in bank one bits 9 and 8.
// RQ17: Event interrupts need the global interrupt enable bit.
// RQ18: Interrupt idle level follows polarity bit, default high idle.
// RQ19: Pin drives interrupt only when output enable set, else power-down input.
// RQ20: Interrupt asserted while any enabled status pending, drops after reads.
// RQ21: Event coinciding with clearing read stays set or counted.
module phy_event_status
    import event_counter_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W+1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic [31:0]            dat_o,
    output logic                   ack_o,
    output logic                   err_o,
    // Bank one event sources (bits 15..10)
    input  wire logic [5:0]        bank_one_evt_i,
    // Bank two event sources
    input  wire logic              eee_error_i,
    input  wire logic              an_error_i,
    input  wire logic              page_received_i,
    input  wire logic              loopback_fifo_error_i,
    input  wire logic              crossover_change_i,
    input  wire logic              sleep_event_i,
    input  wire logic              polarity_inverted_i,
    input  wire logic              wol_packet_i,
    input  wire logic              jabber_i,
    // Counter sources
    input  wire logic              false_carrier_i,
    input  wire logic              rx_data_valid_i,
    input  wire logic              rx_invalid_symbol_i,
    input  wire logic              mii_loopback_i,
    // Interrupt or power-down pin
    input  wire logic              intr_pin_i,
    output logic                   intr_pin_o,
    output logic                   intr_pin_oe_o,
    output logic                   powerdown_o
);

    initial begin
        if (ADDR_W < 8) begin
            $error("phy_event_status ADDR_W must be at least 8");
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] dat;
        logic        ack;
        logic        err;
        logic [15:0] ctrl;
        logic        pin;
        logic        oe;
        logic        pd;
    } state_s;

    state_s st_q;
    state_s st_d;

    logic [ADDR_W-1:0] idx;
    logic              req;
    logic              rd_hit;
    logic              wr_hit;
    logic              lo_we;
    logic [15:0]       b1_val;
    logic [15:0]       b2_val;
    logic              b1_pend;
    logic              b2_pend;
    logic [FC_W-1:0]   fc_cnt;
    logic [RE_W-1:0]   re_cnt;
    logic              fc_half;
    logic              re_half;
    logic              rx_err_evt;
    logic [EVT_W-1:0]  b1_evt;
    logic [EVT_W-1:0]  b2_evt;
    logic              irq;
    logic              evt_irq;
    logic              rd_b1;
    logic              rd_b2;
    logic              rd_fc;
    logic              rd_re;
    logic              wr_b1;
    logic              wr_b2;
    logic              wr_ctl;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == ADDR_W'(IDX_BANK_ONE)) || (a == ADDR_W'(IDX_BANK_TWO)) ||
                 (a == ADDR_W'(IDX_FALSE_CAR)) || (a == ADDR_W'(IDX_RX_ERR)) ||
                 (a == ADDR_W'(IDX_INT_CTRL));
    endfunction

    function automatic logic is_idx(input logic [ADDR_W-1:0] a,
                                    input logic [7:0]        target);
        is_idx = (a == ADDR_W'(target));
    endfunction

    // Read data word for an index; unmapped words read zero
    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                              input logic [15:0]       b1,
                                              input logic [15:0]       b2,
                                              input logic [FC_W-1:0]   fc,
                                              input logic [RE_W-1:0]   re,
                                              input logic [15:0]       ctrl);
        read_word = RD_ZERO;
        case (a)
            ADDR_W'(IDX_BANK_ONE):  read_word = {16'h0000, b1};
            ADDR_W'(IDX_BANK_TWO):  read_word = {16'h0000, b2};
            // RQ10: upper bits read zero
            ADDR_W'(IDX_FALSE_CAR): read_word = {24'h000000, fc};
            ADDR_W'(IDX_RX_ERR):    read_word = {16'h0000, re};
            ADDR_W'(IDX_INT_CTRL):  read_word = {16'h0000, ctrl};
            // Unmapped indices answer with err_o, data stays zero
            default:                read_word = RD_ZERO;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign idx    = adr_i[ADDR_W+1:2];
    assign req    = cyc_i && stb_i && !st_q.ack && !st_q.err;
    assign rd_hit = req && !we_i && mapped(idx);
    assign wr_hit = req && we_i && mapped(idx);
    assign lo_we  = wr_hit && sel_i[0];

    // ------------------------------------------------------------
    // Register strobes
    // ------------------------------------------------------------
    // Reads clear the addressed bank or counter
    assign rd_b1  = rd_hit && is_idx(idx, IDX_BANK_ONE);
    assign rd_b2  = rd_hit && is_idx(idx, IDX_BANK_TWO);
    // RQ12: counter clear strobes
    assign rd_fc  = rd_hit && is_idx(idx, IDX_FALSE_CAR);
    assign rd_re  = rd_hit && is_idx(idx, IDX_RX_ERR);

    // Writes land only through byte lane zero
    assign wr_b1  = lo_we && is_idx(idx, IDX_BANK_ONE);
    assign wr_b2  = lo_we && is_idx(idx, IDX_BANK_TWO);
    assign wr_ctl = lo_we && is_idx(idx, IDX_INT_CTRL);

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    // RQ13: valid carrier with invalid symbol
    // RQ14: no counting in loopback
    assign rx_err_evt = rx_data_valid_i && rx_invalid_symbol_i && !mii_loopback_i;

    // RQ16: half-full into bank one
    assign b1_evt = {bank_one_evt_i, fc_half, re_half};

    // RQ1: EEE error bit 15
    // RQ2: negotiation error bit 14
    // RQ3: page received bit 13
    // RQ4: FIFO error bit 12
    // RQ5: crossover change bit 11
    // RQ6: sleep event bit 10
    // RQ7: shared polarity or wake
    // RQ8: jabber bit 8
    assign b2_evt = {eee_error_i,
                     an_error_i,
                     page_received_i,
                     loopback_fifo_error_i,
                     crossover_change_i,
                     sleep_event_i,
                     polarity_inverted_i | wol_packet_i,
                     jabber_i};

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    event_bank u_bank_one (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .evt_i   (b1_evt),
        .rd_i    (rd_b1),
        .wr_i    (wr_b1),
        .wen_i   (dat_i[EVT_W-1:0]),
        .value_o (b1_val),
        .pend_o  (b1_pend)
    );

    event_bank u_bank_two (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .evt_i   (b2_evt),
        .rd_i    (rd_b2),
        .wr_i    (wr_b2),
        .wen_i   (dat_i[EVT_W-1:0]),
        .value_o (b2_val),
        .pend_o  (b2_pend)
    );

    // RQ10: eight-bit false-carrier count
    // RQ12: clear on read
    sat_counter #(
        .WIDTH (FC_W)
    ) u_false_carrier (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .inc_i   (false_carrier_i),
        .clr_i   (rd_fc),
        .count_o (fc_cnt),
        .half_o  (fc_half)
    );

    // RQ15: limits as printed
    sat_counter #(
        .WIDTH (RE_W)
    ) u_rx_error (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .inc_i   (rx_err_evt),
        .clr_i   (rd_re),
        .count_o (re_cnt),
        .half_o  (re_half)
    );

    // ------------------------------------------------------------
    // Interrupt combine
    // ------------------------------------------------------------
    // RQ17: global enable gates events
    // RQ20: any enabled pending bit
    assign evt_irq = st_q.ctrl[CTRL_INT_EN] && (b1_pend || b2_pend);
    // Test interrupt forces the pin regardless of events
    assign irq     = evt_irq || st_q.ctrl[CTRL_TEST_INT];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d     = st_q;
        st_d.ack = 1'b0;
        st_d.err = 1'b0;
        st_d.dat = RD_ZERO;
        if (req) begin
            st_d.ack = mapped(idx);
            st_d.err = !mapped(idx);
            // Only reads return data
            if (!we_i) begin
                st_d.dat = read_word(idx, b1_val, b2_val, fc_cnt, re_cnt, st_q.ctrl);
            end
        end
        if (wr_ctl) begin
            st_d.ctrl = dat_i[15:0] & CTRL_WMASK;
        end
        // RQ19: pin direction from output enable
        st_d.oe  = st_q.ctrl[CTRL_OUT_EN];
        st_d.pd  = !st_q.ctrl[CTRL_OUT_EN] && intr_pin_i;
        // RQ18: idle level equals polarity bit
        st_d.pin = st_q.ctrl[CTRL_POLARITY] ^ irq;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q      <= '0;
            st_q.ctrl <= CTRL_RESET;
            st_q.pin  <= CTRL_RESET[CTRL_POLARITY];
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign dat_o         = st_q.dat;
    assign ack_o         = st_q.ack;
    assign err_o         = st_q.err;
    assign intr_pin_o    = st_q.pin;
    assign intr_pin_oe_o = st_q.oe;
    assign powerdown_o   = st_q.pd;

endmodule // phy_event_status

// >>> phy_event_status_properties.sv
// Checker: bus answer and pin properties of the event status block
`timescale 1ns/100ps
module phy_event_props
    import event_counter_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W+1:0] adr_i,
    input  wire logic [31:0]       dat_o,
    input  wire logic              ack_o,
    input  wire logic              err_o,
    input  wire logic              intr_pin_o,
    input  wire logic              intr_pin_oe_o,
    input  wire logic              powerdown_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic              take;
    logic [ADDR_W-1:0] idx;
    assign take = cyc_i && stb_i && !ack_o && !err_o;
    assign idx  = adr_i[ADDR_W+1:2];
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    reset_idle_a: assert property (disable iff (1'b0)
        rst_i |=> intr_pin_o && !intr_pin_oe_o)
        else $error("pin not idle after reset");
    pin_mux_a: assert property (intr_pin_oe_o |-> !powerdown_o)
        else $error("power-down active while pin drives");
    answer_once_a: assert property (take |=> ack_o != err_o)
        else $error("request not answered in one cycle");
    answer_pulse_a: assert property (ack_o || err_o |=> !ack_o && !err_o)
        else $error("answer longer than one cycle");
    data_quiet_a: assert property (!ack_o |-> dat_o == RD_ZERO)
        else $error("read data outside ack");
    fc_upper_a: assert property (take && !we_i && idx == ADDR_W'(IDX_FALSE_CAR)
        |=> dat_o[15:8] == 8'h00)
        else $error("false carrier upper bits set");
    re_sat_a: assert property (take && !we_i && idx == ADDR_W'(IDX_RX_ERR)
        |=> dat_o[15:0] <= CNT_MAX)
        else $error("receive error count above limit");
    unmapped_err_a: assert property (take && (idx < ADDR_W'(IDX_INT_CTRL) ||
        idx > ADDR_W'(IDX_RX_ERR)) |=> err_o)
        else $error("unmapped access not refused");
    cover property (take && !we_i);
    cover property (err_o);
    cover property (intr_pin_oe_o && $rose(intr_pin_o));
endmodule // phy_event_props

bind phy_event_status phy_event_props #(.ADDR_W(ADDR_W)) props_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .intr_pin_o(intr_pin_o),
    .intr_pin_oe_o(intr_pin_oe_o), .powerdown_o(powerdown_o));

// >>> phy_event_status_bench.sv
// Testbench: registers, events, counters and interrupt pin
`timescale 1ns/100ps
module phy_event_status_bench
    import event_counter_pkg::*;
;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic        fc = 0, dv = 0, sym = 0, lpbk = 0, pd_drv = 0;
    logic        ack_o, err_o, pin_o, oe_o, pd_o, pin_w;
    logic [9:0]  adr_i = 0;
    logic [31:0] dat_i = 0, dat_o;
    logic [8:0]  ev = 0;
    logic [5:0]  ev1 = 0;
    logic [32:0] exp_q[$];
    logic [15:0] en;
    logic [3:0]  sel = 4'hF;
    int          bad_count = 0, cmp_count = 0, cycles = 0, seed = 68;

    assign pin_w = (oe_o === 1'b1) ? pin_o : pd_drv;
    phy_event_status dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .bank_one_evt_i(ev1), .eee_error_i(ev[8]), .an_error_i(ev[7]),
        .page_received_i(ev[6]), .loopback_fifo_error_i(ev[5]), .crossover_change_i(ev[4]),
        .sleep_event_i(ev[3]), .polarity_inverted_i(ev[2]), .wol_packet_i(ev[1]),
        .jabber_i(ev[0]), .false_carrier_i(fc), .rx_data_valid_i(dv),
        .rx_invalid_symbol_i(sym), .mii_loopback_i(lpbk), .intr_pin_i(pin_w),
        .intr_pin_o(pin_o), .intr_pin_oe_o(oe_o), .powerdown_o(pd_o));

    always #5 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Compare, bus and stimulus tasks
    // ------------------------------------------------------------
    task automatic fail_msg(input logic [32:0] got, input logic [32:0] want);
        bad_count++;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    endtask
    task automatic check_rd(input logic [32:0] got, input logic [32:0] want);
        cmp_count++;
        if (got !== want) fail_msg(got, want);
    endtask
    task automatic check_pin(input logic [2:0] want);
        cmp_count++;
        if ({oe_o, pin_o, pd_o} !== want) fail_msg({oe_o, pin_o, pd_o}, want);
    endtask
    task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d,
                      input logic [32:0] x);
        exp_q.push_back(x);
        cyc_i <= 1;
        stb_i <= 1;
        we_i  <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= {16'h0000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
        cyc_i <= 0;
        stb_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [15:0] v);
        wb(0, idx, 16'h0000, {17'h00000, v});
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        wb(1, idx, d, 33'h0);
    endtask
    task automatic pulse(input int i);
        ev[i] <= 1;
        @(posedge clk_i);
        ev[i] <= 0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic run(input int n, input logic [2:0] s);
        {fc, dv, sym} <= s;
        repeat (n) @(posedge clk_i);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Bus answer monitor for reads and writes
    always @(posedge clk_i) if (ack_o === 1'b1 || err_o === 1'b1) begin
        check_rd({err_o, dat_o}, exp_q.pop_front());
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        repeat (2) @(posedge clk_i);
        check_pin(3'b010);
        rd(IDX_INT_CTRL, CTRL_RESET);
        for (int i = 8'h12; i <= 8'h15; i++) rd(i[7:0], 16'h0000);
        wb(0, 8'h16, 16'h0000, {1'b1, RD_ZERO});
        wb(1, 8'h10, 16'h1234, {1'b1, RD_ZERO});
        sel <= 4'hE;
        wr(IDX_INT_CTRL, 16'h0001);
        sel <= 4'hF;
        rd(IDX_INT_CTRL, CTRL_RESET);
        $display("reset and map test done");
        for (int i = 0; i < 9; i++) begin
            pulse(i);
            en = 16'h0001 << (i == 0 ? 8 : i < 3 ? 9 : i + 7);
            rd(IDX_BANK_TWO, en);
            rd(IDX_BANK_TWO, 16'h0000);
        end
        en = {8'h00, 8'($random(seed))};
        wr(IDX_BANK_TWO, 16'hFF00 | en);
        rd(IDX_BANK_TWO, en);
        $display("event bank test done");
        wr(IDX_BANK_TWO, 16'h0001);
        wr(IDX_INT_CTRL, 16'h0003);
        check_pin(3'b100);
        pulse(0);
        check_pin(3'b110);
        rd(IDX_BANK_TWO, 16'h0101);
        check_pin(3'b100);
        wr(IDX_INT_CTRL, 16'h0001);
        pulse(0);
        check_pin(3'b100);
        rd(IDX_BANK_TWO, 16'h0101);
        wr(IDX_INT_CTRL, 16'h0005);
        check_pin(3'b110);
        wr(IDX_INT_CTRL, 16'h0008);
        pd_drv <= 1;
        repeat (2) @(posedge clk_i);
        check_pin(3'b011);
        pd_drv <= 0;
        $display("interrupt pin test done");
        run(127, 3'b100);
        run(1, 3'b000);
        rd(IDX_FALSE_CAR, 16'h007F);
        rd(IDX_BANK_ONE, 16'h0000);
        run(300, 3'b100);
        run(1, 3'b000);
        rd(IDX_FALSE_CAR, 16'h00FF);
        rd(IDX_BANK_ONE, 16'h0200);
        fork
            rd(IDX_FALSE_CAR, 16'h0000);
            begin
                run(1, 3'b100);
                fc <= 1'b0;
            end
        join
        run(1, 3'b000);
        rd(IDX_FALSE_CAR, 16'h0001);
        $display("false carrier test done");
        lpbk <= 1;
        run(100, 3'b011);
        lpbk <= 0;
        run(50, 3'b011);
        run(10, 3'b001);
        run(1, 3'b000);
        rd(IDX_RX_ERR, 16'h0032);
        wr(IDX_RX_ERR, 16'h1234);
        rd(IDX_RX_ERR, 16'h0000);
        run(300, 3'b011);
        run(1, 3'b000);
        rd(IDX_RX_ERR, 16'h00FF);
        en = 16'($random(seed)) & 16'hFC00;
        ev1 <= en[15:10];
        @(posedge clk_i);
        ev1 <= 0;
        rd(IDX_BANK_ONE, en | 16'h0100);
        $display("receive error test done");
        @(posedge clk_i);
        stop_test();
    end
endmodule // phy_event_status_bench
